/* File: tb/pin_partner.sv */
module pin_partner (
	input  wire logic aclk,
	input  wire logic pin,
	input  wire logic oe,
	output logic      trigger,
	output int        width,
	output int        pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	int run = 0;
	// Trigger line rests low, as with a pull-down
	initial begin
		trigger = 1'b0;
		width = 0;
		pulses = 0;
	end
	// High time of the pin while the timer drives it
	always @(posedge aclk) begin
		if (oe && pin) begin
			run <= run + 1;
		end else if (run != 0) begin
			width  <= run;
			pulses <= pulses + 1;
			run    <= 0;
		end
	end
	// Rising edge held long enough for the synchroniser
	task automatic fire();
		trigger <= 1'b1;
		repeat (6) @(posedge aclk);
		trigger <= 1'b0;
	endtask : fire
endmodule : pin_partner

/* File: tb/timer_compare_pulse_pwm_test.sv */
`include "timer_compare_params.svh"
module timer_compare_pulse_pwm_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, global_irq_mask, capture_input_one, capture_input_two;
	logic        ext_clock_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, compare_output_pin_one, compare_output_oe_one;
	logic        compare_output_pin_two, compare_output_oe_two, timer_irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rd, lfsr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          fail_count = 0, checks_done = 0, cycles = 0, width, pulses, p0;
	int          model[int];
	timer_compare_pulse_pwm dut_u (.*);
	pin_partner partner_u (.aclk(aclk), .pin(compare_output_pin_one),
		.oe(compare_output_oe_one), .trigger(capture_input_one), .width(width), .pulses(pulses));
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	function automatic logic [7:0] lfsr_step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_step
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_width(input int exp, input int got);
		checks_done++;
		if (got < exp - 2 || got > exp + 2) begin
			fail_count++;
			$display("FAIL pulse width expected %0d seen %0d", exp, got);
		end
	endtask : chk_width
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (model.exists(a)) model[a] = d;
	endtask : wr
	task automatic rdb(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata[7:0];
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdb
	task automatic wait_pulse(input int n);
		repeat (n) begin
			p0 = pulses;
			for (int i = 0; i < 2000 && pulses == p0; i++) @(posedge aclk);
		end
	endtask : wait_pulse
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, global_irq_mask, capture_input_two, ext_clock_in} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		lfsr = 8'h49;
		model[8'h0C] = 8'h80;
		model[8'h10] = 8'h00;
		model[8'h14] = 8'h80;
		model[8'h18] = 8'h00;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdb(8'h1C);
		chk("counter high", 16'h00FF, rd);
		foreach (model[a]) begin
			rdb(a[7:0]);
			chk("compare byte", model[a], rd);
		end
		wr(8'h40, 8'h55);
		chk("write resp", `RESP_SLVERR, resp);
		rdb(8'h40);
		chk("read resp", `RESP_SLVERR, resp);
		$display("test reset and map done");
		// Compare at divide-by-2, level high, interrupt on; lone high byte inhibits
		wr(8'h00, 8'h41);
		wr(8'h04, 8'h11);
		wr(8'h10, 8'h20);
		wr(8'h0C, 8'h00);
		wr(8'h20, 8'h00);
		repeat (90) @(posedge aclk);
		chk("pin one", 16'h0000, compare_output_pin_one);
		wr(8'h10, 8'h20);
		wr(8'h20, 8'h00);
		for (int i = 0; i < 300 && compare_output_pin_one !== 1'b1; i++) @(posedge aclk);
		chk("pin one", 16'h0001, compare_output_pin_one);
		chk("oe one", 16'h0001, compare_output_oe_one);
		rdb(8'h08);
		chk("status", 16'h0060, rd);
		chk("irq", 16'h0001, timer_irq);
		global_irq_mask <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("irq", 16'h0000, timer_irq);
		wr(8'h10, 8'h20);
		rdb(8'h08);
		chk("status", 16'h0020, rd);
		$display("test compare done");
		// Forced level on both pins
		wr(8'h00, 8'h08);
		repeat (3) @(posedge aclk);
		chk("pin one", 16'h0000, compare_output_pin_one);
		wr(8'h00, 8'h09);
		repeat (3) @(posedge aclk);
		chk("pin one", 16'h0001, compare_output_pin_one);
		rdb(8'h08);
		chk("status", 16'h0020, rd);
		wr(8'h04, 8'h13);
		wr(8'h00, 8'h14);
		repeat (3) @(posedge aclk);
		chk("pin two", 16'h0001, compare_output_pin_two);
		chk("oe two", 16'h0001, compare_output_oe_two);
		$display("test force done");
		// Pulse-width mode, period 30h, pulse 10h, counter restarted first
		rdb(8'h20);
		wr(8'h20, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h30);
		wr(8'h0C, 8'h00);
		wr(8'h10, 8'h10);
		wr(8'h00, 8'h0C);
		wr(8'h04, 8'h19);
		wait_pulse(2);
		chk_width((16'h10 + 5) * 2, width);
		lfsr = lfsr_step(lfsr);
		v = 8'h08 + {4'h0, lfsr[3:0]};
		wr(8'h10, v);
		wait_pulse(3);
		chk_width((v + 5) * 2, width);
		rdb(8'h08);
		chk("status", 16'h0080, rd & 8'hC8);
		wr(8'h04, 8'h1D);
		wr(8'h0C, 8'h01);
		wait_pulse(3);
		chk_width((v + 5) * 2, width);
		wr(8'h0C, 8'h00);
		wr(8'h10, 8'h20);
		wr(8'h00, 8'h06);
		$display("test pulse width done");
		// Single pulse of 20h counts on a rising trigger; capture two still live
		wait_pulse(1);
		wr(8'h04, 8'h15);
		rdb(8'h08);
		rdb(8'h28);
		partner_u.fire();
		wait_pulse(1);
		chk_width((16'h20 + 5) * 2, width);
		capture_input_two <= 1'b1;
		repeat (3) @(posedge aclk);
		capture_input_two <= 1'b0;
		repeat (5) @(posedge aclk);
		rdb(8'h08);
		chk("status", 16'h0090, rd & 8'hD0);
		$display("test single pulse done");
		end_sim();
	end
endmodule : timer_compare_pulse_pwm_test

/* File: verilog/timer_compare_params.svh */
`ifndef TIMER_COMPARE_PARAMS_SVH
`define TIMER_COMPARE_PARAMS_SVH
// Notes on behaviour
// - Counter equal to a compare value sets that channel's match flag.
// - Match with pin enabled drives the programmed level; pin is low in reset.
// - Interrupt requested only when its enable is set and the global mask is clear.
// - Match flag clears after status read with flag set, then low-byte access.
// - High compare byte write inhibits that channel until its low byte is written.
// - Low-byte write re-enables compare; software writes high, reads status, writes low.
// - Pin enable clear: pin untouched on match, interrupt still possible.
// - Divide-by-2 matches at value; other clocks match at value plus one.
// - Force bit with pin enabled copies level to pin, no flag, no interrupt.
// - Force bits do nothing in single-pulse or pulse-width mode.
// - Single-pulse select in control two; capture one triggers, compare one times.
// - Single-pulse edge: capture, reload FFFC, drive second level, set capture flag.
// - Single-pulse compare-one match drives first level; pulse is count plus five ticks.
// - Single-pulse mode never sets compare flag one; channel two still works.
// - Both mode selects set means only pulse-width mode runs.
// - Single-pulse mode: capture one does no ordinary capture, capture two does.
// - Single-pulse mode: channel two flags time but never drives its pin.
// - Pulse-width mode: compare two sets period, compare one the pulse length.
// - Pulse-width mode: new values reach shadows only at channel-two match.
// - Pulse-width mode: high-byte write blocks shadow transfer until low byte written.
// - Pulse-width mode: comparison always active despite high-byte inhibit.
// - Pulse-width mode: pin one takes level one on match one, level two on two.
// - Pulse-width mode: channel-two match reloads counter to FFFC.
// - Pulse-width mode: compare flags stay clear; capture flag one set at period end.
// - Reset presets compare values to 8000; hardware never changes them.
// - Counter resets to FFFC, wraps FFFF to 0000, setting overflow flag.
`define OFS_CONTROL_ONE  8'h00
`define OFS_CONTROL_TWO  8'h04
`define OFS_STATUS       8'h08
`define OFS_CMP1_HIGH    8'h0C
`define OFS_CMP1_LOW     8'h10
`define OFS_CMP2_HIGH    8'h14
`define OFS_CMP2_LOW     8'h18
`define OFS_COUNT_HIGH   8'h1C
`define OFS_COUNT_LOW    8'h20
`define OFS_CAP1_HIGH    8'h24
`define OFS_CAP1_LOW     8'h28
`define OFS_CAP2_HIGH    8'h2C
`define OFS_CAP2_LOW     8'h30
`define COUNT_RELOAD     16'hFFFC
`define COUNT_TOP        16'hFFFF
`define COMPARE_RESET    16'h8000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

/* File: verilog/timer_compare_pkg.sv */
package timer_compare_pkg;
	typedef enum logic [1:0] {
		CLK_DIV4 = 2'h0,
		CLK_DIV2 = 2'h1,
		CLK_DIV8 = 2'h2,
		CLK_EXT  = 2'h3
	} clk_sel_type;
	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_output_two;
		logic force_output_one;
		logic second_output_level;
		logic capture_edge_select_one;
		logic first_output_level;
	} control_one_type;
	typedef struct packed {
		logic        ext_clock_rising;
		logic        capture_edge_select_two;
		clk_sel_type timer_clock_select;
		logic        pwm_select;
		logic        single_pulse_select;
		logic        compare_pin_enable_two;
		logic        compare_pin_enable_one;
	} control_two_type;
	// Flag order: capture one, compare one, overflow, capture two, compare two
	typedef logic [4:0] flags_type;
endpackage : timer_compare_pkg

/* File: verilog/timer_compare_pulse_pwm.sv */
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`include "timer_compare_params.svh"
module timer_compare_pulse_pwm #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  global_irq_mask,
	input  wire logic                  capture_input_one,
	input  wire logic                  capture_input_two,
	input  wire logic                  ext_clock_in,
	output logic                       compare_output_pin_one,
	output logic                       compare_output_oe_one,
	output logic                       compare_output_pin_two,
	output logic                       compare_output_oe_two,
	output logic                       timer_irq
);
	// Address must reach the highest offset
	if (ADDR_WIDTH < 8) begin : g_addr_check
		$error("ADDR_WIDTH must be at least 8");
	end

	// Word-aligned address match against an 8-bit offset
	function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] ofs);
		hit = (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(ofs[7:2]));
	endfunction : hit

	timer_compare_pkg::control_one_type c1_reg;
	timer_compare_pkg::control_two_type c2_reg;
	timer_compare_pkg::flags_type       flag_reg, armed_reg, set_vec, acc_vec, clr_vec;
	logic [15:0]           cnt_reg, cmp1_reg, cmp2_reg, sh1_reg, sh2_reg;
	logic [15:0]           cap1_reg, cap2_reg, use1, use2, tgt1, tgt2;
	logic [1:0]            inhibit_reg, capinh_reg;
	logic [2:0]            meta_reg, sync_reg, prev_reg, presc_reg;
	logic                  tick, tick_d_reg, edge1, edge2, ext_edge;
	logic                  pwm_on, opm_on, normal, div2, hit1, hit2, match1, match2;
	logic                  wrap, cap1_ev, pin1_reg, pin2_reg, oe1_reg, oe2_reg, irq_reg;
	logic                  awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0]            bresp_reg, rresp_reg, rresp_next;
	logic [31:0]           wdata_reg, rdata_reg, rdata_next;
	logic [3:0]            wstrb_reg;
	logic [ADDR_WIDTH-1:0] awaddr_reg, araddr_reg;
	logic                  wfire, rfire, wok, wmap;
	logic                  w_c1h, w_c1l, w_c2h, w_c2l, w_cntl;
	logic                  r_st, r_c1l, r_c2l, r_cntl, r_p1h, r_p1l, r_p2h, r_p2l;

	// Bus write: address and data taken in either order, answer after both
	assign wfire = !awready_reg && !wready_reg && !bvalid_reg;
	assign wok   = wfire && wstrb_reg[0];
	assign wmap  = hit(awaddr_reg, `OFS_CONTROL_ONE) || hit(awaddr_reg, `OFS_CONTROL_TWO)
		|| hit(awaddr_reg, `OFS_STATUS) || hit(awaddr_reg, `OFS_CMP1_HIGH)
		|| hit(awaddr_reg, `OFS_CMP1_LOW) || hit(awaddr_reg, `OFS_CMP2_HIGH)
		|| hit(awaddr_reg, `OFS_CMP2_LOW) || hit(awaddr_reg, `OFS_COUNT_HIGH)
		|| hit(awaddr_reg, `OFS_COUNT_LOW) || hit(awaddr_reg, `OFS_CAP1_HIGH)
		|| hit(awaddr_reg, `OFS_CAP1_LOW) || hit(awaddr_reg, `OFS_CAP2_HIGH)
		|| hit(awaddr_reg, `OFS_CAP2_LOW);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wfire) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wmap ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Write strobes, lane 0 carries the byte
	assign w_c1h = wok && hit(awaddr_reg, `OFS_CMP1_HIGH);
	assign w_c1l = wok && hit(awaddr_reg, `OFS_CMP1_LOW);
	assign w_c2h = wok && hit(awaddr_reg, `OFS_CMP2_HIGH);
	assign w_c2l = wok && hit(awaddr_reg, `OFS_CMP2_LOW);
	assign w_cntl = wok && hit(awaddr_reg, `OFS_COUNT_LOW);

	// Bus read: data registered one cycle after the address is taken
	assign rfire = !arready_reg && !rvalid_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= `RESP_OKAY;
			araddr_reg  <= '0;
		end else begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				araddr_reg  <= s_axi_araddr;
			end
			if (rfire) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rdata_next;
				rresp_reg  <= rresp_next;
			end
			if (rvalid_reg && s_axi_rready) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// Read data mux
	always_comb begin
		rdata_next = 32'h0000_0000;
		rresp_next = `RESP_OKAY;
		if (hit(araddr_reg, `OFS_CONTROL_ONE))     rdata_next[7:0] = c1_reg;
		else if (hit(araddr_reg, `OFS_CONTROL_TWO)) rdata_next[7:0] = c2_reg;
		else if (hit(araddr_reg, `OFS_STATUS))     rdata_next[7:0] = {flag_reg, 3'h0};
		else if (hit(araddr_reg, `OFS_CMP1_HIGH))  rdata_next[7:0] = cmp1_reg[15:8];
		else if (hit(araddr_reg, `OFS_CMP1_LOW))   rdata_next[7:0] = cmp1_reg[7:0];
		else if (hit(araddr_reg, `OFS_CMP2_HIGH))  rdata_next[7:0] = cmp2_reg[15:8];
		else if (hit(araddr_reg, `OFS_CMP2_LOW))   rdata_next[7:0] = cmp2_reg[7:0];
		else if (hit(araddr_reg, `OFS_COUNT_HIGH)) rdata_next[7:0] = cnt_reg[15:8];
		else if (hit(araddr_reg, `OFS_COUNT_LOW))  rdata_next[7:0] = cnt_reg[7:0];
		else if (hit(araddr_reg, `OFS_CAP1_HIGH))  rdata_next[7:0] = cap1_reg[15:8];
		else if (hit(araddr_reg, `OFS_CAP1_LOW))   rdata_next[7:0] = cap1_reg[7:0];
		else if (hit(araddr_reg, `OFS_CAP2_HIGH))  rdata_next[7:0] = cap2_reg[15:8];
		else if (hit(araddr_reg, `OFS_CAP2_LOW))   rdata_next[7:0] = cap2_reg[7:0];
		else rresp_next = `RESP_SLVERR;
	end

	// Read side-effect strobes
	assign r_st   = rfire && hit(araddr_reg, `OFS_STATUS);
	assign r_c1l  = rfire && hit(araddr_reg, `OFS_CMP1_LOW);
	assign r_c2l  = rfire && hit(araddr_reg, `OFS_CMP2_LOW);
	assign r_cntl = rfire && hit(araddr_reg, `OFS_COUNT_LOW);
	assign r_p1h  = rfire && hit(araddr_reg, `OFS_CAP1_HIGH);
	assign r_p1l  = rfire && hit(araddr_reg, `OFS_CAP1_LOW);
	assign r_p2h  = rfire && hit(araddr_reg, `OFS_CAP2_HIGH);
	assign r_p2l  = rfire && hit(araddr_reg, `OFS_CAP2_LOW);

	// Control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c1_reg <= '0;
			c2_reg <= '0;
		end else begin
			if (wok && hit(awaddr_reg, `OFS_CONTROL_ONE))
				c1_reg <= wdata_reg[7:0];
			if (wok && hit(awaddr_reg, `OFS_CONTROL_TWO))
				c2_reg <= wdata_reg[7:0];
		end
	end

	// Pin synchronisers: capture one, capture two, external clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= {ext_clock_in, capture_input_two, capture_input_one};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end
	assign edge1 = c1_reg.capture_edge_select_one ? (sync_reg[0] && !prev_reg[0])
		: (!sync_reg[0] && prev_reg[0]);
	assign edge2 = c2_reg.capture_edge_select_two ? (sync_reg[1] && !prev_reg[1])
		: (!sync_reg[1] && prev_reg[1]);
	assign ext_edge = c2_reg.ext_clock_rising ? (sync_reg[2] && !prev_reg[2])
		: (!sync_reg[2] && prev_reg[2]);

	// Prescaler and timer tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_reg  <= '0;
			tick_d_reg <= 1'b0;
		end else begin
			presc_reg  <= presc_reg + 3'h1;
			tick_d_reg <= tick;
		end
	end
	always_comb begin
		case (c2_reg.timer_clock_select)
			timer_compare_pkg::CLK_DIV2: tick = presc_reg[0];
			timer_compare_pkg::CLK_DIV4: tick = (presc_reg[1:0] == 2'h3);
			timer_compare_pkg::CLK_DIV8: tick = (presc_reg == 3'h7);
			default:                     tick = ext_edge;
		endcase
	end

	// Mode decode and compare events
	assign pwm_on = c2_reg.pwm_select;
	assign opm_on = c2_reg.single_pulse_select && !pwm_on;
	assign normal = !pwm_on && !opm_on;
	assign div2   = (c2_reg.timer_clock_select == timer_compare_pkg::CLK_DIV2);
	assign use1   = pwm_on ? sh1_reg : cmp1_reg;
	assign use2   = pwm_on ? sh2_reg : cmp2_reg;
	assign tgt1   = div2 ? use1 : use1 + 16'h0001;
	assign tgt2   = div2 ? use2 : use2 + 16'h0001;
	assign hit1   = tick_d_reg && (cnt_reg == tgt1);
	assign hit2   = tick_d_reg && (cnt_reg == tgt2);
	assign match1 = hit1 && (pwm_on || !inhibit_reg[0]);
	assign match2 = hit2 && (pwm_on || !inhibit_reg[1]);
	assign cap1_ev = edge1 && !capinh_reg[0] && normal;
	assign wrap   = tick && (cnt_reg == `COUNT_TOP);

	// Free-running counter with reloads
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_reg <= `COUNT_RELOAD;
		else if (w_cntl || (opm_on && edge1))
			cnt_reg <= `COUNT_RELOAD;
		else if (pwm_on && match2)
			cnt_reg <= `COUNT_RELOAD;
		else if (tick)
			cnt_reg <= cnt_reg + 16'h0001;
	end

	// Compare values, high-byte inhibit, shadows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp1_reg    <= `COMPARE_RESET;
			cmp2_reg    <= `COMPARE_RESET;
			sh1_reg     <= `COMPARE_RESET;
			sh2_reg     <= `COMPARE_RESET;
			inhibit_reg <= '0;
		end else begin
			if (w_c1h) cmp1_reg[15:8] <= wdata_reg[7:0];
			if (w_c1l) cmp1_reg[7:0]  <= wdata_reg[7:0];
			if (w_c2h) cmp2_reg[15:8] <= wdata_reg[7:0];
			if (w_c2l) cmp2_reg[7:0]  <= wdata_reg[7:0];
			inhibit_reg[0] <= w_c1h || (inhibit_reg[0] && !w_c1l);
			inhibit_reg[1] <= w_c2h || (inhibit_reg[1] && !w_c2l);
			if (pwm_on && match2 && !inhibit_reg[0])
				sh1_reg <= cmp1_reg;
			if (pwm_on && match2 && !inhibit_reg[1])
				sh2_reg <= cmp2_reg;
			if (!pwm_on) begin
				sh1_reg <= cmp1_reg;
				sh2_reg <= cmp2_reg;
			end
		end
	end

	// Capture registers; high-byte read freezes until low-byte read, except capture one on a single-pulse trigger
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap1_reg   <= '0;
			cap2_reg   <= '0;
			capinh_reg <= '0;
		end else begin
			if (cap1_ev || (opm_on && edge1))
				cap1_reg <= cnt_reg;
			if (edge2 && !capinh_reg[1])
				cap2_reg <= cnt_reg;
			capinh_reg[0] <= r_p1h || (capinh_reg[0] && !r_p1l);
			capinh_reg[1] <= r_p2h || (capinh_reg[1] && !r_p2l);
		end
	end

	// Flag set and two-step clear; a set in the clearing cycle wins
	assign set_vec = {cap1_ev || (opm_on && edge1) || (pwm_on && match2),
		normal && match1,
		wrap,
		edge2 && !capinh_reg[1],
		!pwm_on && match2};
	assign acc_vec = {r_p1l, r_c1l || w_c1l, r_cntl, r_p2l, r_c2l || w_c2l};
	assign clr_vec = armed_reg & acc_vec;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg  <= '0;
			armed_reg <= '0;
		end else begin
			flag_reg  <= set_vec | (flag_reg & ~clr_vec);
			armed_reg <= (armed_reg | (r_st ? flag_reg : '0)) & ~clr_vec;
		end
	end

	// Output pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin1_reg <= 1'b0;
			pin2_reg <= 1'b0;
			oe1_reg  <= 1'b0;
			oe2_reg  <= 1'b0;
		end else begin
			oe1_reg <= c2_reg.compare_pin_enable_one;
			oe2_reg <= c2_reg.compare_pin_enable_two;
			if (pwm_on) begin
				if (match2)
					pin1_reg <= c1_reg.second_output_level;
				else if (match1)
					pin1_reg <= c1_reg.first_output_level;
			end else if (opm_on) begin
				if (edge1)
					pin1_reg <= c1_reg.second_output_level;
				else if (hit1)
					pin1_reg <= c1_reg.first_output_level;
			end else if (c2_reg.compare_pin_enable_one) begin
				if (c1_reg.force_output_one)
					pin1_reg <= c1_reg.first_output_level;
				else if (match1)
					pin1_reg <= c1_reg.first_output_level;
			end
			if (normal && c2_reg.compare_pin_enable_two) begin
				if (c1_reg.force_output_two || match2)
					pin2_reg <= c1_reg.second_output_level;
			end
		end
	end

	// Interrupt request, gated by enables and the global mask
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= !global_irq_mask &&
				((c1_reg.capture_irq_enable && (flag_reg[4] || flag_reg[1]))
				|| (c1_reg.compare_irq_enable && (flag_reg[3] || flag_reg[0]))
				|| (c1_reg.overflow_irq_enable && flag_reg[2]));
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign compare_output_pin_one = pin1_reg;
	assign compare_output_oe_one  = oe1_reg;
	assign compare_output_pin_two = pin2_reg;
	assign compare_output_oe_two  = oe2_reg;
	assign timer_irq = irq_reg;

	// Checks on the timer behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence opm_edge_s;
		opm_on && edge1;
	endsequence
	sequence pwm_end_s;
		pwm_on && match2;
	endsequence
	sequence flag_read_s;
		flag_reg[3] && r_st;
	endsequence
	cmp_flag_set_a: assert property (normal && match1 |=> flag_reg[3])
		else $error("compare flag one not set on match");
	pin_level_a: assert property (normal && match1 && c2_reg.compare_pin_enable_one
		&& !c1_reg.force_output_one |=> pin1_reg == $past(c1_reg.first_output_level))
		else $error("pin one missed level on match");
	irq_gate_a: assert property (irq_reg |-> !$past(global_irq_mask))
		else $error("interrupt raised while masked");
	flag_clear_a: assert property (flag_read_s ##[1:20] (w_c1l && !set_vec[3])
		|=> !flag_reg[3])
		else $error("compare flag one not cleared");
	force_pin_a: assert property (normal && c1_reg.force_output_one
		&& c2_reg.compare_pin_enable_one |=> pin1_reg == $past(c1_reg.first_output_level))
		else $error("forced level not on pin one");
	opm_trigger_a: assert property (opm_edge_s |=> cnt_reg == `COUNT_RELOAD
		&& flag_reg[4] && pin1_reg == $past(c1_reg.second_output_level))
		else $error("single pulse trigger wrong");
	opm_no_flag_a: assert property (opm_on && $past(opm_on) |-> !$rose(flag_reg[3]))
		else $error("compare flag one set in single pulse mode");
	pwm_reload_a: assert property (pwm_end_s |=> cnt_reg == `COUNT_RELOAD
		&& flag_reg[4])
		else $error("period end did not reload counter");
	rollover_a: assert property (wrap && !w_cntl && !(opm_on && edge1) && !(pwm_on && match2)
		|=> cnt_reg == 16'h0000 && flag_reg[2])
		else $error("counter wrap or overflow flag wrong");
endmodule : timer_compare_pulse_pwm
